/* pkg/cr_pkg.sv */
// Shared constants for the core register set: addresses, layouts, reset values, ALU op codes
// Behaviour
// - 16-bit fetch pointer, low and high byte, reset to 0000h.
// - 8-bit accumulator feeds operands and takes arithmetic, rotate and move results.
// - Multiply and divide pair accumulator with auxiliary register; otherwise auxiliary is scratch.
// - Four banks of eight working registers; status bank bits pick the active one.
// - Banks live in the first 32 bytes of internal RAM from 00h, aliasing.
// - Reset selects bank zero at 00h-07h; stack starts at 08h.
// - Bank code 00,01,10,11 maps to 00h,08h,10h,18h eight-byte windows.
// - Carry set on add carry-out or subtract borrow, cleared by other arithmetic.
// - Shift and rotate instructions move the carry through the operand.
// - Nibble carry set on carry into or borrow from upper nibble, else cleared.
// - One user flag in status word, changed only by software writes.
// - Overflow set on sign change, multiply above 255, or divide by zero.
// - Otherwise those instructions clear overflow; a clear instruction clears it always.
// - Parity flag always equals odd parity of the accumulator.
// - Special registers at 80h-FFh only by direct or bit addressing; indirect reaches RAM.
// - Sixteen special addresses, those ending in 0 or 8, allow bit access.
// - Unimplemented special addresses read as 00h; software should not write them.
// - Stack pointer increments before push, decrements after pop, resets to 07h.
`default_nettype none
package cr_pkg;
   localparam int DATA_W = 8;
   localparam int ADDR_W = 8;
   localparam int RAM_DEPTH = 256;

   localparam logic [15:0] FETCH_RESET = 16'h0000;
   localparam logic [7:0] SP_RESET = 8'h07;
   localparam logic [7:0] ACC_RESET = 8'h00;
   localparam logic [7:0] AUX_RESET = 8'h00;
   localparam logic [1:0] BANK_RESET = 2'h0;
   localparam logic [7:0] UNMAPPED_READ = 8'h00;

   // Special register map
   localparam logic [7:0] ADDR_SP = 8'h81;
   localparam logic [7:0] ADDR_FLAGS = 8'hd0;
   localparam logic [7:0] ADDR_ACC = 8'he0;
   localparam logic [7:0] ADDR_AUX = 8'hf0;

   // Status word bit positions
   localparam int CARRY_BIT = 7;
   localparam int HALF_BIT = 6;
   localparam int USER_BIT = 5;
   localparam int BANK1_BIT = 4;
   localparam int BANK0_BIT = 3;
   localparam int RANGE_BIT = 2;
   localparam int PAR_BIT = 0;

   // ALU operation codes
   localparam logic [3:0] OP_ADD = 4'h0;
   localparam logic [3:0] OP_ADD_CI = 4'h1;
   localparam logic [3:0] OP_SUB_BI = 4'h2;
   localparam logic [3:0] OP_MUL = 4'h3;
   localparam logic [3:0] OP_DIV = 4'h4;
   localparam logic [3:0] OP_RLC = 4'h5;
   localparam logic [3:0] OP_RRC = 4'h6;
   localparam logic [3:0] OP_CLR_RNG = 4'h7;
   localparam logic [3:0] OP_LOADA = 4'h8;
endpackage
`default_nettype wire

/* rtl/cr_alu.sv */
// Arithmetic, multiply/divide and rotate results with their flag updates
`default_nettype none
module cr_alu
   import cr_pkg::*;
(
   input wire logic [3:0] op,
   input wire logic [7:0] acc,
   input wire logic [7:0] aux,
   input wire logic [7:0] operand,
   input wire logic carryIn,
   output logic [7:0] accRes,
   output logic [7:0] auxRes,
   output logic wrAcc,
   output logic wrAux,
   output logic newCarry,
   output logic newHalf,
   output logic newRange,
   output logic updCarry,
   output logic updHalf,
   output logic updRange
);
   logic [8:0] sum9;
   logic [4:0] lo5;
   logic [15:0] prod;
   logic cin;

   always_comb
   begin
      sum9 = '0;
      lo5 = '0;
      prod = '0;
      cin = 1'b0;
      accRes = acc;
      auxRes = aux;
      wrAcc = 1'b0;
      wrAux = 1'b0;
      newCarry = 1'b0;
      newHalf = 1'b0;
      newRange = 1'b0;
      updCarry = 1'b0;
      updHalf = 1'b0;
      updRange = 1'b0;
      case (op)
         OP_ADD, OP_ADD_CI:
         begin
            cin = (op == OP_ADD_CI) ? carryIn : 1'b0;
            sum9 = {1'b0, acc} + {1'b0, operand} + {8'h00, cin};
            lo5 = {1'b0, acc[3:0]} + {1'b0, operand[3:0]} + {4'h0, cin};
            accRes = sum9[7:0];
            newCarry = sum9[8];
            newHalf = lo5[4];
            newRange = (acc[7] == operand[7]) && (sum9[7] != acc[7]);
            {wrAcc, updCarry, updHalf, updRange} = 4'hf;
         end
         OP_SUB_BI:
         begin
            sum9 = {1'b0, acc} - {1'b0, operand} - {8'h00, carryIn};
            lo5 = {1'b0, acc[3:0]} - {1'b0, operand[3:0]} - {4'h0, carryIn};
            accRes = sum9[7:0];
            newCarry = sum9[8];
            newHalf = lo5[4];
            newRange = (acc[7] != operand[7]) && (sum9[7] != acc[7]);
            {wrAcc, updCarry, updHalf, updRange} = 4'hf;
         end
         OP_MUL:
         begin
            prod = {8'h00, acc} * {8'h00, aux};
            accRes = prod[7:0];
            auxRes = prod[15:8];
            newRange = (prod[15:8] != 8'h00);
            {wrAcc, wrAux, updCarry, updHalf, updRange} = 5'h1f;
         end
         OP_DIV:
         begin
            // Divide by zero leaves both operands untouched
            if (aux != 8'h00)
            begin
               accRes = acc / aux;
               auxRes = acc % aux;
               wrAcc = 1'b1;
               wrAux = 1'b1;
            end
            newRange = (aux == 8'h00);
            {updCarry, updHalf, updRange} = 3'h7;
         end
         OP_RLC:
         begin
            accRes = {acc[6:0], carryIn};
            newCarry = acc[7];
            wrAcc = 1'b1;
            updCarry = 1'b1;
         end
         OP_RRC:
         begin
            accRes = {carryIn, acc[7:1]};
            newCarry = acc[0];
            wrAcc = 1'b1;
            updCarry = 1'b1;
         end
         OP_CLR_RNG:
         begin
            updRange = 1'b1;
         end
         OP_LOADA:
         begin
            accRes = operand;
            wrAcc = 1'b1;
         end
         default:
         begin
            wrAcc = 1'b0;
         end
      endcase
   end
endmodule
`default_nettype wire

/* rtl/cr_core_regs.sv */
// Core register set: fetch pointer, accumulator, auxiliary, status word, stack pointer, banked RAM
`default_nettype none
module cr_core_regs
   import cr_pkg::*;
(
   input wire logic clock,
   input wire logic nrst,
   input wire logic fetchAdvance,
   input wire logic pcLoad,
   input wire logic [15:0] pcLoadValue,
   input wire logic dirRd,
   input wire logic dirWr,
   input wire logic [7:0] dirAddr,
   input wire logic [7:0] dirWdata,
   input wire logic bitRd,
   input wire logic bitWr,
   input wire logic [7:0] bitAddr,
   input wire logic bitValue,
   input wire logic indRd,
   input wire logic indWr,
   input wire logic [7:0] indAddr,
   input wire logic [7:0] indWdata,
   input wire logic workRd,
   input wire logic workWr,
   input wire logic [2:0] workIdx,
   input wire logic [7:0] workWdata,
   input wire logic stackPush,
   input wire logic stackPop,
   input wire logic [7:0] pushData,
   input wire logic aluGo,
   input wire logic [3:0] aluOp,
   input wire logic [7:0] aluOperand,
   output logic [7:0] rdData,
   output logic rdValid,
   output logic [15:0] fetchPtr,
   output logic [7:0] accOut,
   output logic [7:0] auxOut,
   output logic [7:0] flagsOut,
   output logic [7:0] stackPtr
);
   logic [15:0] fetch_q;
   logic [7:0] acc_q;
   logic [7:0] acc_d;
   logic [7:0] aux_q;
   logic [7:0] aux_d;
   logic [7:0] sp_q;
   logic [7:0] sp_d;
   logic carry_q;
   logic nibble_q;
   logic user_q;
   logic [1:0] bank_q;
   logic range_q;
   logic parity_q;
   logic [7:0] psw_d;
   logic [7:0] pswNow;
   logic [7:0] rdData_q;
   logic [7:0] rdData_d;
   logic rdValid_q;

   logic [7:0] bitByte;
   logic [2:0] bitIdx;
   logic bitSfr;
   logic dirSfr;
   logic [7:0] workAddr;
   logic [7:0] spInc;

   logic ramWe;
   logic [7:0] ramWaddr;
   logic [7:0] ramWdata;
   logic [7:0] ramRaddr;
   logic [7:0] ramRdata;

   logic [7:0] aluAcc;
   logic [7:0] aluAux;
   logic aluWrAcc;
   logic aluWrAux;
   logic aluCarry;
   logic aluHalf;
   logic aluRange;
   logic aluUpdCarry;
   logic aluUpdHalf;
   logic aluUpdRange;

   // Address at or above the special space base; indirect paths never call this
   function automatic logic isSfr(input logic [7:0] addr);
      return addr[7];
   endfunction

   // Byte write or single-bit write into a special register
   function automatic logic [7:0] sfrMerge(
      input logic [7:0] old,
      input logic byteWe,
      input logic [7:0] data,
      input logic bitWe,
      input logic [2:0] idx,
      input logic val
   );
      logic [7:0] r;
      r = old;
      if (byteWe)
      begin
         r = data;
      end
      if (bitWe)
      begin
         r[idx] = val;
      end
      return r;
   endfunction

   // Current value of a special register; unmapped addresses give a fixed byte
   function automatic logic [7:0] sfrRead(input logic [7:0] addr);
      logic [7:0] r;
      r = UNMAPPED_READ;
      case (addr)
         ADDR_SP: r = sp_q;
         ADDR_FLAGS: r = pswNow;
         ADDR_ACC: r = acc_q;
         ADDR_AUX: r = aux_q;
         default: r = UNMAPPED_READ;
      endcase
      return r;
   endfunction

   // Bit access only where the byte address ends in 0 or 8
   assign bitSfr = isSfr(bitAddr);
   assign bitByte = {bitAddr[7:3], 3'b000};
   assign bitIdx = bitAddr[2:0];
   assign dirSfr = isSfr(dirAddr);
   assign workAddr = {3'b000, bank_q, workIdx};
   assign spInc = sp_q + 8'h01;

   always_comb
   begin
      pswNow = 8'h00;
      pswNow[CARRY_BIT] = carry_q;
      pswNow[HALF_BIT] = nibble_q;
      pswNow[USER_BIT] = user_q;
      pswNow[BANK1_BIT] = bank_q[1];
      pswNow[BANK0_BIT] = bank_q[0];
      pswNow[RANGE_BIT] = range_q;
      pswNow[PAR_BIT] = parity_q;
   end

   cr_alu u_alu (
      .op(aluOp),
      .acc(acc_q),
      .aux(aux_q),
      .operand(aluOperand),
      .carryIn(carry_q),
      .accRes(aluAcc),
      .auxRes(aluAux),
      .wrAcc(aluWrAcc),
      .wrAux(aluWrAux),
      .newCarry(aluCarry),
      .newHalf(aluHalf),
      .newRange(aluRange),
      .updCarry(aluUpdCarry),
      .updHalf(aluUpdHalf),
      .updRange(aluUpdRange)
   );

   cr_iram #(
      .DEPTH(RAM_DEPTH),
      .AW(ADDR_W),
      .DW(DATA_W)
   ) u_iram (
      .clock(clock),
      .we(ramWe),
      .waddr(ramWaddr),
      .wdata(ramWdata),
      .raddr(ramRaddr),
      .rdata(ramRdata)
   );

   // One RAM write per cycle: push, then working register, indirect, direct
   always_comb
   begin
      ramWe = 1'b0;
      ramWaddr = 8'h00;
      ramWdata = 8'h00;
      if (stackPush)
      begin
         ramWe = 1'b1;
         ramWaddr = spInc;
         ramWdata = pushData;
      end
      else if (workWr)
      begin
         ramWe = 1'b1;
         ramWaddr = workAddr;
         ramWdata = workWdata;
      end
      else if (indWr)
      begin
         // Upper half through a pointer is plain RAM
         ramWe = 1'b1;
         ramWaddr = indAddr;
         ramWdata = indWdata;
      end
      else if (dirWr && !dirSfr)
      begin
         ramWe = 1'b1;
         ramWaddr = dirAddr;
         ramWdata = dirWdata;
      end
   end

   // Read select and returned byte, same priority as writes
   always_comb
   begin
      ramRaddr = 8'h00;
      rdData_d = rdData_q;
      if (stackPop)
      begin
         ramRaddr = sp_q;
         rdData_d = ramRdata;
      end
      else if (workRd)
      begin
         ramRaddr = workAddr;
         rdData_d = ramRdata;
      end
      else if (indRd)
      begin
         ramRaddr = indAddr;
         rdData_d = ramRdata;
      end
      else if (dirRd)
      begin
         ramRaddr = dirAddr;
         rdData_d = dirSfr ? sfrRead(dirAddr) : ramRdata;
      end
      else if (bitRd)
      begin
         // Bits below the special space are not mapped here
         rdData_d = 8'h00;
         if (bitSfr)
         begin
            rdData_d[0] = 1'(sfrRead(bitByte) >> bitIdx);
         end
      end
   end

   always_ff @(posedge clock)
   begin
      if (!nrst)
      begin
         rdData_q <= 8'h00;
         rdValid_q <= 1'b0;
      end
      else
      begin
         rdData_q <= rdData_d;
         rdValid_q <= stackPop | workRd | indRd | dirRd | bitRd;
      end
   end

   // Fetch pointer: a load beats an advance
   always_ff @(posedge clock)
   begin
      if (!nrst)
      begin
         fetch_q <= FETCH_RESET;
      end
      else if (pcLoad)
      begin
         fetch_q <= pcLoadValue;
      end
      else if (fetchAdvance)
      begin
         fetch_q <= fetch_q + 16'h0001;
      end
   end

   // Accumulator: the ALU result overrides a software write in the same cycle
   always_comb
   begin
      acc_d = sfrMerge(acc_q, dirWr && dirAddr == ADDR_ACC, dirWdata,
                       bitWr && bitSfr && bitByte == ADDR_ACC, bitIdx, bitValue);
      if (aluGo && aluWrAcc)
      begin
         acc_d = aluAcc;
      end
   end

   always_comb
   begin
      aux_d = sfrMerge(aux_q, dirWr && dirAddr == ADDR_AUX, dirWdata,
                       bitWr && bitSfr && bitByte == ADDR_AUX, bitIdx, bitValue);
      if (aluGo && aluWrAux)
      begin
         aux_d = aluAux;
      end
   end

   always_ff @(posedge clock)
   begin
      if (!nrst)
      begin
         acc_q <= ACC_RESET;
         aux_q <= AUX_RESET;
      end
      else
      begin
         acc_q <= acc_d;
         aux_q <= aux_d;
      end
   end

   // Parity tracks the next accumulator so it never lags a write
   always_ff @(posedge clock)
   begin
      if (!nrst)
      begin
         parity_q <= 1'b0;
      end
      else
      begin
         parity_q <= ^acc_d;
      end
   end

   // Stack pointer: push pre-increments, pop post-decrements
   always_comb
   begin
      sp_d = sfrMerge(sp_q, dirWr && dirAddr == ADDR_SP, dirWdata, 1'b0, bitIdx, bitValue);
      if (stackPush)
      begin
         sp_d = spInc;
      end
      else if (stackPop)
      begin
         sp_d = sp_q - 8'h01;
      end
   end

   always_ff @(posedge clock)
   begin
      if (!nrst)
      begin
         sp_q <= SP_RESET;
      end
      else
      begin
         sp_q <= sp_d;
      end
   end

   // Status word; the parity position is read-only and ignores writes
   always_comb
   begin
      psw_d = sfrMerge(pswNow, dirWr && dirAddr == ADDR_FLAGS, dirWdata,
                       bitWr && bitSfr && bitByte == ADDR_FLAGS, bitIdx, bitValue);
      if (aluGo && aluUpdCarry)
      begin
         psw_d[CARRY_BIT] = aluCarry;
      end
      if (aluGo && aluUpdHalf)
      begin
         psw_d[HALF_BIT] = aluHalf;
      end
      if (aluGo && aluUpdRange)
      begin
         psw_d[RANGE_BIT] = aluRange;
      end
   end

   always_ff @(posedge clock)
   begin
      if (!nrst)
      begin
         carry_q <= 1'b0;
         nibble_q <= 1'b0;
         user_q <= 1'b0;
         bank_q <= BANK_RESET;
         range_q <= 1'b0;
      end
      else
      begin
         carry_q <= psw_d[CARRY_BIT];
         nibble_q <= psw_d[HALF_BIT];
         user_q <= psw_d[USER_BIT];
         bank_q <= {psw_d[BANK1_BIT], psw_d[BANK0_BIT]};
         range_q <= psw_d[RANGE_BIT];
      end
   end

   assign rdData = rdData_q;
   assign rdValid = rdValid_q;
   assign fetchPtr = fetch_q;
   assign accOut = acc_q;
   assign auxOut = aux_q;
   assign flagsOut = pswNow;
   assign stackPtr = sp_q;
endmodule
`default_nettype wire

/* rtl/cr_iram.sv */
// Internal data RAM: one write port, one asynchronous read port
`default_nettype none
module cr_iram
   import cr_pkg::*;
#(
   parameter int DEPTH = RAM_DEPTH,
   parameter int AW = ADDR_W,
   parameter int DW = DATA_W
)
(
   input wire logic clock,
   input wire logic we,
   input wire logic [AW-1:0] waddr,
   input wire logic [DW-1:0] wdata,
   input wire logic [AW-1:0] raddr,
   output logic [DW-1:0] rdata
);
   logic [DW-1:0] mem [DEPTH];

   // Contents are not reset, as in the real data RAM
   always_ff @(posedge clock)
   begin
      if (we)
      begin
         mem[waddr] <= wdata;
      end
   end

   assign rdata = mem[raddr];
endmodule
`default_nettype wire

/* sim/cr_core_regs_sva.sv */
// Port-level assertions for the core register set, bound into the top module
`default_nettype none
module cr_core_regs_sva import cr_pkg::*;
(
   input wire logic clock,
   input wire logic nrst,
   input wire logic fetchAdvance,
   input wire logic pcLoad,
   input wire logic [15:0] pcLoadValue,
   input wire logic dirRd,
   input wire logic dirWr,
   input wire logic [7:0] dirAddr,
   input wire logic bitRd,
   input wire logic bitWr,
   input wire logic [7:0] bitAddr,
   input wire logic indRd,
   input wire logic indWr,
   input wire logic workRd,
   input wire logic workWr,
   input wire logic stackPush,
   input wire logic stackPop,
   input wire logic [7:0] pushData,
   input wire logic aluGo,
   input wire logic [3:0] aluOp,
   input wire logic [7:0] aluOperand,
   input wire logic [7:0] rdData,
   input wire logic rdValid,
   input wire logic [15:0] fetchPtr,
   input wire logic [7:0] accOut,
   input wire logic [7:0] auxOut,
   input wire logic [7:0] flagsOut,
   input wire logic [7:0] stackPtr
);
   timeunit 1ns;
   timeprecision 1ps;
   logic anyRd;
   assign anyRd = dirRd | indRd | workRd | bitRd | stackPop;
   default clocking cb @(posedge clock); endclocking
   default disable iff (!nrst);
   // A write to the popped address in between would legally change the byte
   sequence s_push_then_pop;
      stackPush ##1 (stackPop && !stackPush && !workWr && !indWr && !dirWr);
   endsequence
   a_reset_values: assert property ($rose(nrst) |->
      fetchPtr == 16'h0000 && stackPtr == 8'h07 && flagsOut == 8'h00)
      else $error("reset values wrong");
   a_fetch_step: assert property (fetchAdvance && !pcLoad |=> fetchPtr == $past(fetchPtr) + 16'h0001)
      else $error("fetch pointer did not step");
   a_fetch_load: assert property (pcLoad |=> fetchPtr == $past(pcLoadValue))
      else $error("fetch pointer did not load");
   a_parity_odd: assert property (flagsOut[0] == ^accOut)
      else $error("parity flag wrong");
   a_read_answer: assert property (anyRd |=> rdValid)
      else $error("read gave no valid pulse");
   a_push_grows: assert property (stackPush |=> stackPtr == $past(stackPtr) + 8'h01)
      else $error("stack pointer not raised by push");
   a_pop_shrinks: assert property (stackPop && !stackPush |=> stackPtr == $past(stackPtr) - 8'h01)
      else $error("stack pointer not lowered by pop");
   a_pop_data: assert property (s_push_then_pop |=> rdValid && rdData == $past(pushData, 2))
      else $error("popped byte differs from pushed byte");
   a_mul_pair: assert property (aluGo && aluOp == 4'h3 |=>
      {auxOut, accOut} == $past(accOut) * $past(auxOut) && flagsOut[2] == (auxOut != 8'h00) && !flagsOut[7])
      else $error("multiply result or flags wrong");
   a_div_zero: assert property (aluGo && aluOp == OP_DIV && auxOut == 8'h00 |=>
      flagsOut[2] && $stable(accOut) && $stable(auxOut))
      else $error("divide by zero handled wrongly");
   a_clear_range: assert property (aluGo && aluOp == 4'h7 |=> !flagsOut[2])
      else $error("overflow not cleared");
   a_load_acc: assert property (aluGo && aluOp == OP_LOADA |=> accOut == $past(aluOperand))
      else $error("accumulator load wrong");
   a_indirect_ram: assert property (indWr && !aluGo && !dirWr |=> $stable(accOut))
      else $error("indirect write reached a special register");
   a_user_flag: assert property ($changed(flagsOut[5]) |->
      $past(dirWr && dirAddr == 8'hd0 || bitWr && bitAddr == 8'hd5))
      else $error("user flag changed without a software write");
endmodule
bind cr_core_regs cr_core_regs_sva u_cr_core_regs_sva (.clock, .nrst, .fetchAdvance, .pcLoad, .pcLoadValue,
   .dirRd, .dirWr, .dirAddr, .bitRd, .bitWr, .bitAddr, .indRd, .indWr, .workRd, .workWr, .stackPush, .stackPop,
   .pushData, .aluGo, .aluOp, .aluOperand, .rdData, .rdValid, .fetchPtr, .accOut, .auxOut, .flagsOut, .stackPtr);
`default_nettype wire

/* sim/test_cr_core_regs.sv */
// Self-checking testbench for the core register set
`default_nettype none
`define CHK(a, b) begin checks_done++; if ((a) !== (b)) begin n_mismatch++; \
   $display("BAD t=%0t got=%h exp=%h", $time, (a), (b)); end end
module test_cr_core_regs import cr_pkg::*;;
   timeunit 1ns;
   timeprecision 1ps;
   logic clock = 1'h0, nrst = 1'h0, fetchAdvance = 1'h0, pcLoad = 1'h0, bitValue = 1'h0, aluGo = 1'h0;
   logic dirRd = 1'h0, dirWr = 1'h0, bitRd = 1'h0, bitWr = 1'h0, indRd = 1'h0, indWr = 1'h0;
   logic workRd = 1'h0, workWr = 1'h0, stackPush = 1'h0, stackPop = 1'h0, rdValid;
   logic [15:0] pcLoadValue = 16'h0000, fetchPtr;
   logic [7:0] dirAddr = 8'h00, dirWdata = 8'h00, bitAddr = 8'h00, indAddr = 8'h00, indWdata = 8'h00;
   logic [7:0] workWdata = 8'h00, pushData = 8'h00, aluOperand = 8'h00, junk, q;
   logic [7:0] rdData, accOut, auxOut, flagsOut, stackPtr;
   logic [3:0] aluOp = 4'h0;
   logic [2:0] workIdx = 3'h0;
   int n_mismatch = 0;
   int checks_done = 0;
   cr_core_regs u_cr_core_regs (.clock(clock), .nrst(nrst), .fetchAdvance(fetchAdvance), .pcLoad(pcLoad),
      .pcLoadValue(pcLoadValue), .dirRd(dirRd), .dirWr(dirWr), .dirAddr(dirAddr), .dirWdata(dirWdata),
      .bitRd(bitRd), .bitWr(bitWr), .bitAddr(bitAddr), .bitValue(bitValue), .indRd(indRd), .indWr(indWr),
      .indAddr(indAddr), .indWdata(indWdata), .workRd(workRd), .workWr(workWr), .workIdx(workIdx),
      .workWdata(workWdata), .stackPush(stackPush), .stackPop(stackPop), .pushData(pushData), .aluGo(aluGo),
      .aluOp(aluOp), .aluOperand(aluOperand), .rdData(rdData), .rdValid(rdValid), .fetchPtr(fetchPtr),
      .accOut(accOut), .auxOut(auxOut), .flagsOut(flagsOut), .stackPtr(stackPtr));
   initial
   begin
      forever #5 clock = ~clock;
   end
   // Kind: 0 direct, 1 indirect, 2 bit, 3 working register, 4 stack
   task automatic xfer(input bit wrt, input int kind, input logic [7:0] a, input logic [7:0] d, output logic [7:0] r);
      @(negedge clock);
      {dirAddr, indAddr, bitAddr} = {a, a, a};
      workIdx = a[2:0];
      {dirWdata, indWdata, workWdata, pushData} = {d, d, d, d};
      bitValue = d[0];
      {dirWr, indWr, bitWr, workWr, stackPush} = wrt ? 5'h10 >> kind : 5'h00;
      {dirRd, indRd, bitRd, workRd, stackPop} = wrt ? 5'h00 : 5'h10 >> kind;
      @(negedge clock);
      {dirWr, indWr, bitWr, workWr, stackPush} = 5'h00;
      {dirRd, indRd, bitRd, workRd, stackPop} = 5'h00;
      r = rdData;
   endtask
   task automatic alu(input logic [3:0] op, input logic [7:0] v);
      @(negedge clock) aluGo = 1'h1;
      aluOp = op;
      aluOperand = v;
      @(negedge clock) aluGo = 1'h0;
   endtask
   // Carry, nibble carry, overflow
   task automatic fl(input logic [2:0] e);
      `CHK({flagsOut[7:6], flagsOut[2]}, e)
   endtask
   task automatic t_reset;
      `CHK(fetchPtr, 16'h0000)
      `CHK(stackPtr, 8'h07)
      `CHK(flagsOut[4:3], 2'h0)
      $display("test reset done");
   endtask
   task automatic t_fetch;
      @(negedge clock) fetchAdvance = 1'h1;
      repeat (3) @(negedge clock);
      fetchAdvance = 1'h0;
      `CHK(fetchPtr, 16'h0003)
      @(negedge clock) pcLoad = 1'h1;
      pcLoadValue = 16'hffff;
      fetchAdvance = 1'h1;
      @(negedge clock) pcLoad = 1'h0;
      `CHK(fetchPtr, 16'hffff)
      @(negedge clock) fetchAdvance = 1'h0;
      `CHK(fetchPtr, 16'h0000)
      $display("test fetch done");
   endtask
   task automatic t_banks;
      for (int b = 0; b < 4; b++)
      begin
         xfer(1'h1, 0, 8'hd0, 8'(b << 3), junk);
         `CHK(flagsOut[4:3], 2'(b))
         xfer(1'h1, 3, 8'h05, 8'ha0 + 8'(b), junk);
         xfer(1'h0, 0, 8'(b * 8 + 5), 8'h00, q);
         `CHK(q, 8'ha0 + 8'(b))
         xfer(1'h0, 3, 8'h05, 8'h00, q);
         `CHK(q, 8'ha0 + 8'(b))
      end
      xfer(1'h1, 0, 8'hd0, 8'h00, junk);
      $display("test banks done");
   endtask
   task automatic t_regs;
      xfer(1'h1, 0, 8'he0, 8'h3c, junk);
      xfer(1'h0, 0, 8'he0, 8'h00, q);
      `CHK({q, flagsOut[0]}, 9'h078)
      xfer(1'h1, 0, 8'hf0, 8'h81, junk);
      `CHK(auxOut, 8'h81)
      alu(OP_LOADA, 8'h07);
      `CHK(flagsOut[0], 1'h1)
      $display("test registers done");
   endtask
   task automatic t_arith;
      alu(OP_LOADA, 8'h78);
      alu(OP_ADD, 8'h08);
      `CHK(accOut, 8'h80)
      fl(3'h3);
      alu(OP_ADD, 8'h80);
      fl(3'h5);
      alu(4'h1, 8'h00);
      `CHK(accOut, 8'h01)
      fl(3'h0);
      alu(4'h2, 8'h02);
      `CHK(accOut, 8'hff)
      fl(3'h6);
      alu(4'h2, 8'h7f);
      `CHK(accOut, 8'h7f)
      fl(3'h3);
      $display("test arithmetic done");
   endtask
   task automatic t_muldiv;
      alu(OP_LOADA, 8'h20);
      xfer(1'h1, 0, 8'hf0, 8'h10, junk);
      alu(4'h3, 8'h00);
      `CHK({auxOut, accOut}, 16'h0200)
      fl(3'h1);
      alu(OP_LOADA, 8'h0f);
      xfer(1'h1, 0, 8'hf0, 8'h03, junk);
      alu(4'h3, 8'h00);
      `CHK({auxOut, accOut}, 16'h002d)
      fl(3'h0);
      alu(OP_LOADA, 8'h0a);
      xfer(1'h1, 0, 8'hf0, 8'h03, junk);
      alu(OP_DIV, 8'h00);
      `CHK({auxOut, accOut}, 16'h0103)
      fl(3'h0);
      xfer(1'h1, 0, 8'hf0, 8'h00, junk);
      alu(OP_DIV, 8'h00);
      `CHK({auxOut, accOut}, 16'h0003)
      fl(3'h1);
      alu(4'h7, 8'h00);
      fl(3'h0);
      $display("test multiply and divide done");
   endtask
   task automatic t_rotate;
      alu(OP_LOADA, 8'h00);
      alu(OP_ADD, 8'h00);
      alu(OP_LOADA, 8'h81);
      alu(OP_RLC, 8'h00);
      `CHK({flagsOut[7], accOut}, 9'h102)
      alu(OP_RRC, 8'h00);
      `CHK({flagsOut[7], accOut}, 9'h081)
      $display("test rotate done");
   endtask
   task automatic t_special;
      xfer(1'h1, 1, 8'he0, 8'h5a, junk);
      `CHK(accOut, 8'h81)
      xfer(1'h0, 1, 8'he0, 8'h00, q);
      `CHK(q, 8'h5a)
      xfer(1'h1, 0, 8'h80, 8'haa, junk);
      xfer(1'h0, 0, 8'h80, 8'h00, q);
      `CHK(q, 8'h00)
      xfer(1'h1, 2, 8'hd5, 8'h01, junk);
      `CHK(flagsOut[5], 1'h1)
      xfer(1'h0, 2, 8'hd5, 8'h00, q);
      `CHK(q[0], 1'h1)
      xfer(1'h1, 2, 8'he1, 8'h01, junk);
      `CHK({accOut, flagsOut[0]}, 9'h107)
      alu(OP_ADD, 8'h01);
      `CHK(flagsOut[5], 1'h1)
      xfer(1'h1, 2, 8'hd0, 8'h01, junk);
      `CHK(flagsOut[0], 1'h0)
      $display("test special space done");
   endtask
   task automatic t_stack;
      xfer(1'h1, 4, 8'h00, 8'h55, junk);
      `CHK(stackPtr, 8'h08)
      xfer(1'h0, 0, 8'h08, 8'h00, q);
      `CHK(q, 8'h55)
      xfer(1'h1, 4, 8'h00, 8'h66, junk);
      xfer(1'h0, 4, 8'h00, 8'h00, q);
      `CHK({q, stackPtr}, 16'h6608)
      xfer(1'h0, 4, 8'h00, 8'h00, q);
      `CHK({q, stackPtr}, 16'h5507)
      // Back-to-back push and pop, the only path where pop reads the push of the cycle before
      @(negedge clock) stackPush = 1'h1;
      pushData = 8'h77;
      @(negedge clock) stackPush = 1'h0;
      stackPop = 1'h1;
      @(negedge clock) stackPop = 1'h0;
      `CHK({rdValid, rdData, stackPtr}, 17'h17707)
      $display("test stack done");
   endtask
   task automatic t_midreset;
      @(negedge clock) nrst = 1'h0;
      repeat (3) @(negedge clock);
      nrst = 1'h1;
      `CHK({accOut, stackPtr, flagsOut}, 24'h000700)
      $display("test second reset done");
   endtask
   task automatic final_report;
      $display("checks %0d, mismatches %0d", checks_done, n_mismatch);
      if (n_mismatch == 0 && checks_done > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask
   initial
   begin
      repeat (20) @(negedge clock);
      nrst = 1'h1;
      t_reset();
      t_fetch();
      t_banks();
      t_regs();
      t_arith();
      t_muldiv();
      t_rotate();
      t_special();
      t_stack();
      t_midreset();
      final_report();
   end
   // Whole run is about 150 cycles; this only trips on a hang
   initial
   begin
      #20000;
      n_mismatch++;
      final_report();
   end
endmodule
`undef CHK
`default_nettype wire
